// ---- verilog/tocs_regs.vh ----
// register map, field positions and codes for the timer output and clock select block
// assumes a word-addressed bus slave: the index below is the word address

`ifndef TOCS_REGS_VH
`define TOCS_REGS_VH

// register indices, byte address is four times the index
`define TOCS_IDX_PRESCALE   16'hff61
`define TOCS_IDX_OUTCTL     16'hff63
`define TOCS_IDX_STATUS     16'hff64

// reset values
`define TOCS_RST_PRESCALE   8'h00
`define TOCS_RST_OUTCTL     8'h00

// count_clock_and_edge_select fields
`define TOCS_CLKSEL         1:0
`define TOCS_ES0_LSB        4
`define TOCS_ES_STRIDE      2
`define TOCS_PRESCALE_MASK  8'hf3

// timer_output_control bits
`define TOCS_OE_BIT         0
`define TOCS_INV1_BIT       1
`define TOCS_RSTFF_BIT      2
`define TOCS_SETFF_BIT      3
`define TOCS_INV2_BIT       4
`define TOCS_OSMODE_BIT     5
`define TOCS_OSTRIG_BIT     6
`define TOCS_OUTCTL_MASK    8'h33

// count clock select codes
`define TOCS_CS_FULL        2'b00
`define TOCS_CS_DIV4        2'b01
`define TOCS_CS_DIV256      2'b10
`define TOCS_CS_PIN         2'b11
`define TOCS_DIV4_MASK      8'h03
`define TOCS_DIV256_MASK    8'hff

// counter operating modes, bits [2:1] of the mode input
`define TOCS_MODE_STOP      2'b00
`define TOCS_MODE_FREE      2'b01
`define TOCS_MODE_PINCLR    2'b10
`define TOCS_MODE_MATCHCLR  2'b11

`endif

// ---- verilog/tocs_top.v ----
// timer output flip-flop, one-shot control, count clock prescaler and input edge filters
// assumes the counter datapath sits on SYS_CLK and supplies mode, match and overflow
// pins arrive asynchronously; registers are reached over an Avalon-MM slave
//
// Register access over Avalon-MM is this design's own decision.

`include "tocs_regs.vh"
`timescale 1ns/1ns
`default_nettype none

module tocs_top (
  input  wire        SYS_CLK,
  input  wire        RST,
  input  wire [15:0] AVS_ADDRESS,
  input  wire        AVS_READ,
  input  wire        AVS_WRITE,
  input  wire [31:0] AVS_WRITEDATA,
  input  wire [3:0]  AVS_BYTEENABLE,
  output reg  [31:0] AVS_READDATA,
  output reg         AVS_WAITREQUEST,
  input  wire [2:0]  COUNTER_MODE,
  input  wire        FIRST_MATCH,
  input  wire        SECOND_MATCH,
  input  wire        COUNTER_OVERFLOW,
  input  wire        FIRST_TIMER_INPUT,
  input  wire        SECOND_TIMER_INPUT,
  output reg         TIMER_OUTPUT_PIN,
  output reg         COUNT_TICK,
  output reg         FIRST_PIN_EDGE,
  output reg         SECOND_PIN_EDGE,
  output reg         ONESHOT_START
);

  reg  [7:0]  prescale_r;
  reg  [7:0]  outctl_r;
  reg  [7:0]  div_r;
  reg         out_ff_r;
  reg         armed_r;
  reg  [31:0] rd_mux;
  reg         tick_nxt;

  wire        req;
  wire        commit;
  wire        wr_lo;
  wire        wr_pre;
  wire        wr_out;
  wire [7:0]  wd;
  wire [1:0]  mode;
  wire        running;
  wire [1:0]  clksel;
  wire [1:0]  pins;
  wire [1:0]  samp_en;
  wire [1:0]  edge_w;
  wire [1:0]  filt_w;
  wire        os_mode;
  wire        os_ok;
  wire        sw_set;
  wire        sw_clr;
  wire        sw_trig;
  wire        start;
  wire        inv_ev;
  wire        inv_gate;

  // bus decode; a write lands only at the edge that sees waitrequest low
  assign req    = AVS_READ | AVS_WRITE;
  assign commit = req & ~AVS_WAITREQUEST;
  assign wr_lo  = commit & AVS_WRITE & AVS_BYTEENABLE[0];
  assign wr_pre = wr_lo & (AVS_ADDRESS == `TOCS_IDX_PRESCALE);
  assign wr_out = wr_lo & (AVS_ADDRESS == `TOCS_IDX_OUTCTL);
  assign wd     = AVS_WRITEDATA[7:0];

  // counter state as seen from the mode input
  assign mode    = COUNTER_MODE[2:1];
  assign running = (mode != `TOCS_MODE_STOP);
  assign clksel  = prescale_r[`TOCS_CLKSEL];

  // read mux; only the low byte carries data, the rest reads zero
  always @* begin
    case (AVS_ADDRESS)
      `TOCS_IDX_PRESCALE: begin
        rd_mux = {24'h000000, prescale_r & `TOCS_PRESCALE_MASK};
      end
      `TOCS_IDX_OUTCTL: begin
        // trigger, set and reset are never stored, so they read zero
        rd_mux = {24'h000000, outctl_r & `TOCS_OUTCTL_MASK};
      end
      `TOCS_IDX_STATUS: begin
        rd_mux = {27'h0000000, armed_r, filt_w, running, out_ff_r};
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // one wait state per access: the first edge latches read data and
  // drops waitrequest, the next edge completes the transfer
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h00000000;
    end else if (req && AVS_WAITREQUEST) begin
      AVS_WAITREQUEST <= 1'b0;
      AVS_READDATA    <= rd_mux;
    end else begin
      AVS_WAITREQUEST <= 1'b1;
    end
  end

  // control registers; software is trusted to write them only when stopped
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      prescale_r <= `TOCS_RST_PRESCALE;
      outctl_r   <= `TOCS_RST_OUTCTL;
    end else begin
      if (wr_pre) begin
        prescale_r <= wd & `TOCS_PRESCALE_MASK;
      end
      if (wr_out) begin
        outctl_r <= wd & `TOCS_OUTCTL_MASK;
      end
    end
  end

  // free prescaler; held at zero while stopped so the first period is whole
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      div_r <= 8'h00;
    end else if (running) begin
      div_r <= div_r + 8'h01;
    end else begin
      div_r <= 8'h00;
    end
  end

  // count clock select
  always @* begin
    case (clksel)
      `TOCS_CS_FULL: begin
        tick_nxt = running;
      end
      `TOCS_CS_DIV4: begin
        tick_nxt = running & ((div_r & `TOCS_DIV4_MASK) == `TOCS_DIV4_MASK);
      end
      `TOCS_CS_DIV256: begin
        tick_nxt = running & (div_r == `TOCS_DIV256_MASK);
      end
      `TOCS_CS_PIN: begin
        tick_nxt = edge_w[0];
      end
      default: begin
        tick_nxt = 1'b0;
      end
    endcase
  end

  // first pin samples every clock when it is the count clock,
  // otherwise both pins sample on the selected count clock
  assign pins    = {SECOND_TIMER_INPUT, FIRST_TIMER_INPUT};
  assign samp_en = {COUNT_TICK, (clksel == `TOCS_CS_PIN) | COUNT_TICK};

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : pin_g
      reg        sync1_r;
      reg        sync2_r;
      reg        samp_r;
      reg        filt_r;
      wire [1:0] es;
      wire       agree;
      wire       rise;
      wire       fall;

      assign es    = prescale_r[`TOCS_ES0_LSB + `TOCS_ES_STRIDE * g +: 2];
      assign agree = running & samp_en[g] & (samp_r == sync2_r);
      assign rise  = agree & sync2_r & ~filt_r;
      assign fall  = agree & ~sync2_r & filt_r;

      // code 10 is forbidden to software; here it behaves as falling edge, like 00
      assign edge_w[g] = (rise & es[0]) | (fall & (es[1] | ~es[0]));
      assign filt_w[g] = filt_r;

      // two-flop synchroniser; only the second stage feeds logic
      always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          sync1_r <= 1'b0;
          sync2_r <= 1'b0;
        end else begin
          sync1_r <= pins[g];
          sync2_r <= sync1_r;
        end
      end

      // noise filter: level accepted after two equal samples; frozen
      // while stopped, so a change across stop/start shows as an edge
      always @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
          samp_r <= 1'b0;
          filt_r <= 1'b0;
        end else if (running && samp_en[g]) begin
          samp_r <= sync2_r;
          if (samp_r == sync2_r) begin
            filt_r <= sync2_r;
          end
        end
      end
    end
  endgenerate

  // one-shot qualification
  assign os_mode = outctl_r[`TOCS_OSMODE_BIT];
  assign os_ok   = (mode == `TOCS_MODE_FREE) | (mode == `TOCS_MODE_PINCLR);
  assign sw_trig = wr_out & wd[`TOCS_OSTRIG_BIT] & wd[`TOCS_OSMODE_BIT] & os_ok;
  assign start   = sw_trig | (os_mode & (mode == `TOCS_MODE_PINCLR) & edge_w[0]);

  // software level control; the forbidden 11 code changes nothing
  assign sw_set = wr_out & wd[`TOCS_SETFF_BIT] & ~wd[`TOCS_RSTFF_BIT];
  assign sw_clr = wr_out & wd[`TOCS_RSTFF_BIT] & ~wd[`TOCS_SETFF_BIT];

  // inversion sources, merged so that coincident events toggle once
  assign inv_ev = (outctl_r[`TOCS_INV1_BIT] & FIRST_MATCH)
                | (outctl_r[`TOCS_INV2_BIT] & SECOND_MATCH)
                | (COUNTER_MODE[0] & edge_w[0]);

  // continuous mode inverts freely; one-shot only between start and overflow
  assign inv_gate = running & (~os_mode | armed_r);

  // one-shot window; a start in the overflow cycle keeps it open
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      armed_r <= 1'b0;
    end else if (!os_mode || !os_ok) begin
      armed_r <= 1'b0;
    end else if (start) begin
      armed_r <= 1'b1;
    end else if (COUNTER_OVERFLOW) begin
      armed_r <= 1'b0;
    end
  end

  // output flip-flop; a software level write outranks a match
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      out_ff_r <= 1'b0;
    end else if (sw_set) begin
      out_ff_r <= 1'b1;
    end else if (sw_clr) begin
      out_ff_r <= 1'b0;
    end else if (inv_ev && inv_gate) begin
      out_ff_r <= ~out_ff_r;
    end
  end

  // pin and event outputs, all registered; the pin lags the ff by one cycle
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      TIMER_OUTPUT_PIN <= 1'b0;
      COUNT_TICK       <= 1'b0;
      FIRST_PIN_EDGE   <= 1'b0;
      SECOND_PIN_EDGE  <= 1'b0;
      ONESHOT_START    <= 1'b0;
    end else begin
      TIMER_OUTPUT_PIN <= outctl_r[`TOCS_OE_BIT] & out_ff_r;
      COUNT_TICK       <= tick_nxt;
      FIRST_PIN_EDGE   <= edge_w[0];
      SECOND_PIN_EDGE  <= edge_w[1];
      ONESHOT_START    <= sw_trig;
    end
  end

endmodule

`default_nettype wire

// ---- testbench/tocs_pin_src.sv ----
// external pulse sources driving the two timer input pins
// assumes the bench asks for levels; the source holds each one whole
`timescale 1ns/1ns
`default_nettype none
module tocs_pin_src (
  input  wire logic       clk,
  input  wire logic [1:0] want,
  output var  logic [1:0] pins
);
  // pins are always driven, so no released state is modelled
  initial pins = 2'b00;
  // levels move just after an edge, held from a single clock to many count clocks
  always @(posedge clk) pins <= want;
endmodule
`default_nettype wire

// ---- testbench/tocs_top_sva.sv ----
// port assertions for the timer output and clock select block
// assumes one clock domain and a bus master that holds requests
`timescale 1ns/1ns
`default_nettype none
module tocs_top_sva (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0]  AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [2:0]  COUNTER_MODE,
  input wire logic        TIMER_OUTPUT_PIN,
  input wire logic        COUNT_TICK,
  input wire logic        FIRST_PIN_EDGE,
  input wire logic        SECOND_PIN_EDGE,
  input wire logic        ONESHOT_START
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  logic       oe_r;
  logic [7:0] q_sh;
  wire oc_wr = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS == 16'hff63;
  wire quiet = COUNTER_MODE[2:1] == 2'b00 && !oc_wr;
  wire os_ok = oc_wr && AVS_WRITEDATA[6] && AVS_WRITEDATA[5] && (COUNTER_MODE[2] ^ COUNTER_MODE[1]);
  // shadow of the enable bit; long history so late pulses settle first
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      oe_r <= 1'b0;
      q_sh <= 8'h00;
    end else begin
      if (oc_wr) oe_r <= AVS_WRITEDATA[0];
      q_sh <= {q_sh[6:0], quiet};
    end
  end
  property p_ack; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
  a_ack: assert property (p_ack) else $error("bus request not answered");
  property p_one; !AVS_WAITREQUEST |=> AVS_WAITREQUEST; endproperty
  a_one: assert property (p_one) else $error("ready held too long");
  property p_rdz; AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 16'hff63 |-> (AVS_READDATA & 32'hcc) == 32'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("write-only bits read back");
  property p_hi; AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read data not zero");
  property p_os; ONESHOT_START |-> $past(os_ok) || $past(os_ok, 2); endproperty
  a_os: assert property (p_os) else $error("one-shot start without trigger");
  property p_oe; !oe_r && !$past(oe_r) |-> !TIMER_OUTPUT_PIN; endproperty
  a_oe: assert property (p_oe) else $error("pin high while disabled");
  property p_hold; &q_sh |-> $stable(TIMER_OUTPUT_PIN); endproperty
  a_hold: assert property (p_hold) else $error("pin moved with no cause");
  property p_tick; &q_sh |-> !COUNT_TICK; endproperty
  a_tick: assert property (p_tick) else $error("count tick while stopped");
  property p_edge; &q_sh |-> !FIRST_PIN_EDGE && !SECOND_PIN_EDGE; endproperty
  a_edge: assert property (p_edge) else $error("pin edge while stopped");
endmodule
bind tocs_top tocs_top_sva u_sva (.SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .COUNTER_MODE(COUNTER_MODE),
  .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN), .COUNT_TICK(COUNT_TICK),
  .FIRST_PIN_EDGE(FIRST_PIN_EDGE), .SECOND_PIN_EDGE(SECOND_PIN_EDGE),
  .ONESHOT_START(ONESHOT_START));
`default_nettype wire

// ---- testbench/test_tocs_top.sv ----
// self-checking bench for the timer output and clock select block
// assumes the design top, the pin source model and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, a, e); end end
module test_tocs_top;
  logic        clk, rst, rd_s, wr_s, fm, sm, ov, wreq, pin_o, tick, e1, e2, os, s1, s2, so;
  logic [15:0] adr;
  logic [31:0] wd, rdat;
  logic [2:0]  mode;
  logic [1:0]  want, pins;
  logic [7:0]  got;
  int          error_cnt, n_compared, cyc, n, k;
  tocs_pin_src u_src (.clk(clk), .want(want), .pins(pins));
  tocs_top uut (.SYS_CLK(clk), .RST(rst), .AVS_ADDRESS(adr), .AVS_READ(rd_s),
    .AVS_WRITE(wr_s), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'h1), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wreq), .COUNTER_MODE(mode), .FIRST_MATCH(fm), .SECOND_MATCH(sm),
    .COUNTER_OVERFLOW(ov), .FIRST_TIMER_INPUT(pins[0]), .SECOND_TIMER_INPUT(pins[1]),
    .TIMER_OUTPUT_PIN(pin_o), .COUNT_TICK(tick), .FIRST_PIN_EDGE(e1),
    .SECOND_PIN_EDGE(e2), .ONESHOT_START(os));
  task give_verdict;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // one bus access, held until ready is seen at an edge
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a;
    wd <= {24'h0, d};
    rd_s <= !w;
    wr_s <= w;
    do @(posedge clk); while (wreq !== 1'b0);
    got = rdat[7:0];
    rd_s <= 1'b0;
    wr_s <= 1'b0;
  endtask
  task rchk(input logic [15:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    `CHK(got, e)
  endtask
  task cy(input int c);
    repeat (c) @(posedge clk);
  endtask
  // sticky capture of short output pulses
  task watch(input int c);
    s1 = 0;
    s2 = 0;
    so = 0;
    repeat (c) begin
      @(posedge clk);
      s1 |= e1;
      s2 |= e2;
      so |= os;
    end
  endtask
  task hit(input logic a, input logic b);
    @(posedge clk);
    fm <= a;
    sm <= b;
    @(posedge clk);
    fm <= 1'b0;
    sm <= 1'b0;
    cy(2);
  endtask
  task t_regs;
    rchk(16'hff61, 8'h00);
    rchk(16'hff63, 8'h00);
    bus(1'b1, 16'hff61, 8'hff);
    rchk(16'hff61, 8'hf3);
    bus(1'b1, 16'hff63, 8'hf7);
    rchk(16'hff63, 8'h33);
    bus(1'b1, 16'h0000, 8'hff);
    rchk(16'h0000, 8'h00);
    bus(1'b1, 16'hff61, 8'h00);
  endtask
  task t_out;
    bus(1'b1, 16'hff63, 8'h09);
    cy(2);
    `CHK(pin_o, 1'b1)
    bus(1'b1, 16'hff63, 8'h01);
    cy(2);
    `CHK(pin_o, 1'b1)
    bus(1'b1, 16'hff63, 8'h05);
    cy(2);
    `CHK(pin_o, 1'b0)
    bus(1'b1, 16'hff63, 8'h08);
    cy(2);
    `CHK(pin_o, 1'b0)
  endtask
  task t_inv;
    bus(1'b1, 16'hff63, 8'h03);
    mode <= 3'b010;
    hit(1'b1, 1'b0);
    `CHK(pin_o, 1'b0)
    hit(1'b0, 1'b1);
    `CHK(pin_o, 1'b0)
    mode <= 3'b000;
    bus(1'b1, 16'hff63, 8'h13);
    mode <= 3'b010;
    hit(1'b1, 1'b1);
    `CHK(pin_o, 1'b1)
    hit(1'b0, 1'b1);
    `CHK(pin_o, 1'b0)
  endtask
  task t_os;
    mode <= 3'b000;
    bus(1'b1, 16'hff63, 8'h20);
    mode <= 3'b010;
    bus(1'b1, 16'hff63, 8'h60);
    watch(3);
    `CHK(so, 1'b1)
    rchk(16'hff63, 8'h20);
    ov <= 1'b1;
    bus(1'b1, 16'hff63, 8'h20);
    ov <= 1'b0;
    watch(3);
    `CHK(so, 1'b0)
    mode <= 3'b110;
    bus(1'b1, 16'hff63, 8'h60);
    watch(3);
    `CHK(so, 1'b0)
  endtask
  task t_clk;
    for (k = 0; k < 3; k++) begin
      mode <= 3'b000;
      bus(1'b1, 16'hff61, k[7:0]);
      mode <= 3'b010;
      cy(10);
      n = 0;
      repeat (512) begin
        @(posedge clk);
        n += (tick === 1'b1);
      end
      `CHK(n, (k == 0) ? 512 : (k == 1) ? 128 : 2)
    end
  endtask
  task t_edge;
    mode <= 3'b000;
    bus(1'b1, 16'hff61, 8'hd0);
    want <= 2'b11;
    cy(8);
    mode <= 3'b010;
    watch(12);
    `CHK({s1, s2}, 2'b11)
    mode <= 3'b000;
    bus(1'b1, 16'hff61, 8'h00);
    want <= 2'b00;
    cy(8);
    mode <= 3'b010;
    watch(12);
    `CHK({s1, s2}, 2'b11)
    want <= 2'b11;
    watch(10);
    `CHK(s1, 1'b0)
    want <= 2'b00;
    @(posedge clk);
    want <= 2'b11;
    watch(10);
    `CHK(s1, 1'b0)
    want <= 2'b00;
    watch(10);
    `CHK(s1, 1'b1)
  endtask
  // first pin edge as count clock and as output inversion source
  task t_pin;
    mode <= 3'b000;
    bus(1'b1, 16'hff63, 8'h01);
    bus(1'b1, 16'hff61, 8'h13);
    want <= 2'b00;
    cy(8);
    mode <= 3'b011;
    want <= 2'b01;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      n += (tick === 1'b1);
    end
    `CHK(n, 1)
    `CHK(pin_o, 1'b1)
    mode <= 3'b000;
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // hang guard well above the under two thousand cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 8000) begin
      error_cnt++;
      give_verdict;
    end
  end
  initial begin
    {rst, rd_s, wr_s, fm, sm, ov} = 6'h20;
    adr = 16'h0000;
    wd = 32'h0;
    mode = 3'b000;
    want = 2'b00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_out;
    t_inv;
    t_os;
    t_clk;
    t_edge;
    t_pin;
    give_verdict;
  end
endmodule
`default_nettype wire
